// [include/cpu_decode_pkg.sv]
package cpu_decode_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses of aligned 32-bit words
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_DECODE = 8'h08;
   localparam logic [7:0] REG_OPERAND = 8'h0c;
   localparam logic [7:0] REG_COUNT = 8'h10;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic CTRL_ENABLE_RST = 1'h0;
   localparam int STAT_HALT_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int DEC_OPCODE_LSB = 0;
   localparam int DEC_LEN_LSB = 8;
   localparam int DEC_TAKEN_BIT = 12;
   localparam int DEC_ILLEGAL_BIT = 13;
   localparam int DEC_CYC_LSB = 16;
   localparam int DEC_CLASS_LSB = 24;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   ////////////////////////////////////////////////////////////////////////////
   // Instruction fields and processor clock counts
   localparam logic [2:0] REG_FIELD_MEM = 3'h6;
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;
   localparam logic [4:0] CYC_SHORT = 5'h04;
   localparam logic [4:0] CYC_REG = 5'h05;
   localparam logic [4:0] CYC_MEM = 5'h07;
   localparam logic [4:0] CYC_WORD = 5'h0a;
   localparam logic [4:0] CYC_PUSH = 5'h0b;
   localparam logic [4:0] CYC_DIRECT_ACC = 5'h0d;
   localparam logic [4:0] CYC_DIRECT_HL = 5'h10;
   localparam logic [4:0] CYC_CALL = 5'h11;
   localparam logic [4:0] CYC_SWAP_STACK = 5'h12;
   typedef enum logic [4:0] {
      no_operation = 5'b00000, copy_op = 5'b00001, halt_op = 5'b00010,
      load_immediate_byte = 5'b00011, inc_byte = 5'b00100, dec_byte = 5'b00101,
      acc_reg_op = 5'b00110, acc_imm_op = 5'b00111, acc_misc_op = 5'b01000,
      jump_op = 5'b01001, call_op = 5'b01010, return_op = 5'b01011,
      restart_op = 5'b01100, port_in_op = 5'b01101, port_out_op = 5'b01110,
      load_pair_imm = 5'b01111, push_op = 5'b10000, pop_op = 5'b10001,
      pair_add_hl = 5'b10010, inc_pair = 5'b10011, dec_pair = 5'b10100,
      swap_stack_top_hl = 5'b10101, swap_de_hl = 5'b10110,
      hl_to_prog_counter = 5'b10111, hl_to_stack_ptr = 5'b11000,
      store_acc_direct = 5'b11001, load_acc_direct = 5'b11010,
      store_hl_direct = 5'b11011, load_hl_direct = 5'b11100,
      store_acc_indirect = 5'b11101, load_acc_indirect = 5'b11110,
      irq_control_op = 5'b11111
   } op_class_t;
   typedef enum logic [1:0] {
      st_opcode = 2'b00,
      st_low = 2'b01,
      st_high = 2'b10
   } fetch_state_t;
   function automatic logic reg_is_mem(input logic [2:0] field);
      return field == REG_FIELD_MEM;
   endfunction : reg_is_mem
endpackage : cpu_decode_pkg

// [core/op_decode.sv]
`timescale 1ns/1ps
module op_decode
   import cpu_decode_pkg::*;
(
   input wire logic [7:0] opcode,
   output op_class_t op_class,
   output logic [1:0] insn_len,
   output logic [4:0] cyc_base,
   output logic [4:0] cyc_alt,
   output logic cond_used,
   output logic illegal,
   output logic [2:0] dest_reg_field,
   output logic [2:0] src_reg_field,
   output logic [1:0] pair_field,
   output logic dest_is_mem,
   output logic src_is_mem
);
   assign dest_reg_field = opcode[5:3];
   assign src_reg_field = opcode[2:0];
   assign pair_field = opcode[5:4];
   assign dest_is_mem = reg_is_mem(dest_reg_field);
   assign src_is_mem = reg_is_mem(src_reg_field);

   ////////////////////////////////////////////////////////////////////////////
   // Exact opcodes sit ahead of the patterns that would swallow them
   always_comb begin
      op_class = no_operation;
      insn_len = LEN_ONE;
      cyc_base = CYC_SHORT;
      cyc_alt = CYC_SHORT;
      cond_used = 1'b0;
      illegal = 1'b0;
      casez (opcode)
         8'b00000000: op_class = no_operation;
         8'b11111011, 8'b11110011: op_class = irq_control_op;
         8'b01110110: begin op_class = halt_op; cyc_base = CYC_MEM; end
         8'b11001001: begin op_class = return_op; cyc_base = CYC_WORD; end
         8'b11000011: begin op_class = jump_op; cyc_base = CYC_WORD; insn_len = LEN_THREE; end
         8'b11001101: begin op_class = call_op; cyc_base = CYC_CALL; insn_len = LEN_THREE; end
         8'b11011011, 8'b11010011: begin
            op_class = opcode[3] ? port_in_op : port_out_op;
            cyc_base = CYC_WORD;
            insn_len = LEN_TWO;
         end
         8'b11100011: begin op_class = swap_stack_top_hl; cyc_base = CYC_SWAP_STACK; end
         8'b11101011: op_class = swap_de_hl;
         8'b11101001: begin op_class = hl_to_prog_counter; cyc_base = CYC_REG; end
         8'b11111001: begin op_class = hl_to_stack_ptr; cyc_base = CYC_REG; end
         8'b00110010, 8'b00111010: begin
            op_class = opcode[3] ? load_acc_direct : store_acc_direct;
            cyc_base = CYC_DIRECT_ACC;
            insn_len = LEN_THREE;
         end
         8'b00100010, 8'b00101010: begin
            op_class = opcode[3] ? load_hl_direct : store_hl_direct;
            cyc_base = CYC_DIRECT_HL;
            insn_len = LEN_THREE;
         end
         8'b000?0010, 8'b000?1010: begin
            op_class = opcode[3] ? load_acc_indirect : store_acc_indirect;
            cyc_base = CYC_MEM;
         end
         8'b01??????: begin
            op_class = copy_op;
            cyc_base = (dest_is_mem || src_is_mem) ? CYC_MEM : CYC_REG;
         end
         8'b00???110: begin
            op_class = load_immediate_byte;
            insn_len = LEN_TWO;
            cyc_base = dest_is_mem ? CYC_WORD : CYC_MEM;
         end
         8'b00???100, 8'b00???101: begin
            op_class = opcode[0] ? dec_byte : inc_byte;
            cyc_base = dest_is_mem ? CYC_WORD : CYC_REG;
         end
         8'b10??????: begin
            op_class = acc_reg_op;
            cyc_base = src_is_mem ? CYC_MEM : CYC_SHORT;
         end
         8'b11???110: begin
            op_class = acc_imm_op;
            insn_len = LEN_TWO;
            cyc_base = CYC_MEM;
         end
         8'b00???111: op_class = acc_misc_op;
         8'b11???000: begin
            op_class = return_op;
            cond_used = 1'b1;
            cyc_base = CYC_REG;
            cyc_alt = CYC_PUSH;
         end
         8'b11???010: begin
            op_class = jump_op;
            cond_used = 1'b1;
            insn_len = LEN_THREE;
            cyc_base = CYC_WORD;
            cyc_alt = CYC_WORD;
         end
         8'b11???100: begin
            op_class = call_op;
            cond_used = 1'b1;
            insn_len = LEN_THREE;
            cyc_base = CYC_PUSH;
            cyc_alt = CYC_CALL;
         end
         8'b11???111: begin op_class = restart_op; cyc_base = CYC_PUSH; end
         8'b00??0001: begin
            op_class = load_pair_imm;
            insn_len = LEN_THREE;
            cyc_base = CYC_WORD;
         end
         8'b11??0101: begin op_class = push_op; cyc_base = CYC_PUSH; end
         8'b11??0001: begin op_class = pop_op; cyc_base = CYC_WORD; end
         8'b00??1001: begin op_class = pair_add_hl; cyc_base = CYC_WORD; end
         8'b00??0011: begin op_class = inc_pair; cyc_base = CYC_REG; end
         8'b00??1011: begin op_class = dec_pair; cyc_base = CYC_REG; end
         default: illegal = 1'b1;
      endcase
   end
endmodule : op_decode

// [core/cpu_instruction_decoder.sv]
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - Every byte is unsigned eight-bit, bit seven top
// - Instructions span one to three consecutive bytes
// - Second byte low half, third byte high
// - High level means one, low means zero
// - Copy 5/7 cycles, halt, immediate 7/10
// - Accumulator register operations take 4 or 7
// - Immediate accumulator operations: two bytes, 7 cycles
// - Rotate and carry operations take 4 cycles
// - Conditional return 5/11, plain return 10
// - Jumps 10, conditional call 11/17, call 17
// - Port input and output: two bytes, 10
// - Pair immediate load: three bytes, 10 cycles
// - Push pair 11 cycles, field 11 flags
// - Pop pair 10 cycles, field 11 flags
// - Pair added to H-L in 10 cycles
// - Pair step 5, byte step 5 or 10
// - Stack swap 18, pair swap 4 cycles
// - H-L to counter or stack pointer: 5
// - Direct loads 13/16, pair-addressed loads 7
// - Interrupt enable, disable, no-operation take 4
// - Restart is one-byte call to fixed vector
module cpu_instruction_decoder
   import cpu_decode_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic fetch_valid,
   output logic fetch_ready,
   input wire logic [7:0] fetch_byte,
   input wire logic flag_zero,
   input wire logic flag_carry,
   input wire logic flag_parity,
   input wire logic flag_sign,
   output logic insn_done,
   output logic [7:0] insn_opcode,
   output logic [15:0] insn_operand,
   output op_class_t insn_class,
   output logic [1:0] insn_len,
   output logic [4:0] insn_cycles,
   output logic insn_taken,
   output logic [2:0] dest_reg_field,
   output logic [2:0] src_reg_field,
   output logic [1:0] pair_field,
   output logic [15:0] restart_vector,
   output logic halted
);
   fetch_state_t state_q, state_d;
   logic [7:0] opcode_q, low_q;
   logic taken_q, finish, fetch_fire;
   logic [7:0] dec_in;
   op_class_t dec_class;
   logic [1:0] dec_len;
   logic [4:0] dec_cyc_base, dec_cyc_alt;
   logic dec_cond, dec_illegal, cond_now, take_now;
   logic [2:0] dec_dst;
   logic done_q, taken_out_q, illegal_q, enable_q, halted_q;
   logic [7:0] out_opcode_q, out_low_q, out_high_q;
   op_class_t class_q;
   logic [1:0] len_q;
   logic [4:0] cyc_q;
   logic [31:0] count_q;
   logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q, rd_word, dec_word;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic wr_fire, rd_fire, wr_ctrl, wr_status, halt_clear, halt_set;

   function automatic logic addr_known(input logic [7:0] a);
      return a == REG_CTRL || a == REG_STATUS || a == REG_DECODE ||
             a == REG_OPERAND || a == REG_COUNT;
   endfunction : addr_known

   ////////////////////////////////////////////////////////////////////////////
   // Byte fetch and assembly
   // Bytes are taken whole, high level as one, with no reinterpretation
   assign fetch_ready = enable_q && !halted_q;
   assign fetch_fire = fetch_valid && fetch_ready;
   assign dec_in = (state_q == st_opcode) ? fetch_byte : opcode_q;

   op_decode u_op_decode (
      .opcode(dec_in),
      .op_class(dec_class),
      .insn_len(dec_len),
      .cyc_base(dec_cyc_base),
      .cyc_alt(dec_cyc_alt),
      .cond_used(dec_cond),
      .illegal(dec_illegal),
      .dest_reg_field(dec_dst),
      .src_reg_field(),
      .pair_field(),
      .dest_is_mem(),
      .src_is_mem()
   );

   // Flags are sampled with the opcode byte; later flag motion is ignored
   assign cond_now = dec_dst[0] ^ ~(dec_dst[2:1] == 2'b00 ? flag_zero :
                     dec_dst[2:1] == 2'b01 ? flag_carry :
                     dec_dst[2:1] == 2'b10 ? flag_parity : flag_sign);
   assign take_now = (state_q == st_opcode) ? (dec_cond && cond_now) : taken_q;

   // Last byte of the instruction by its decoded length
   assign finish = fetch_fire && ((state_q == st_opcode && dec_len == LEN_ONE) ||
                   (state_q == st_low && dec_len == LEN_TWO) || state_q == st_high);

   always_comb begin
      state_d = state_q;
      case (state_q)
         st_opcode: if (fetch_fire && dec_len != LEN_ONE) state_d = st_low;
         st_low: if (fetch_fire) state_d = (dec_len == LEN_THREE) ? st_high : st_opcode;
         st_high: if (fetch_fire) state_d = st_opcode;
         default: state_d = st_opcode;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= st_opcode;
         opcode_q <= 8'h00;
         low_q <= 8'h00;
         taken_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (fetch_fire && state_q == st_opcode) begin
            opcode_q <= fetch_byte;
            taken_q <= take_now;
         end
         if (fetch_fire && state_q == st_low) low_q <= fetch_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoded result, held until the next instruction completes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_q <= 1'b0;
         out_opcode_q <= 8'h00;
         out_low_q <= 8'h00;
         out_high_q <= 8'h00;
         class_q <= no_operation;
         len_q <= 2'h0;
         cyc_q <= 5'h00;
         taken_out_q <= 1'b0;
         illegal_q <= 1'b0;
         count_q <= 32'h0;
      end else begin
         done_q <= finish;
         if (finish) begin
            out_opcode_q <= dec_in;
            out_low_q <= (state_q == st_opcode) ? 8'h00 : (state_q == st_low) ? fetch_byte : low_q;
            out_high_q <= (state_q == st_high) ? fetch_byte : 8'h00;
            class_q <= dec_class;
            len_q <= dec_len;
            cyc_q <= take_now ? dec_cyc_alt : dec_cyc_base;
            taken_out_q <= take_now;
            illegal_q <= dec_illegal;
            count_q <= count_q + 32'h1;
         end
      end
   end

   assign insn_done = done_q;
   assign insn_opcode = out_opcode_q;
   assign insn_operand = {out_high_q, out_low_q};
   assign insn_class = class_q;
   assign insn_len = len_q;
   assign insn_cycles = cyc_q;
   assign insn_taken = taken_out_q;
   assign dest_reg_field = out_opcode_q[5:3];
   assign src_reg_field = out_opcode_q[2:0];
   // Field 11 in push and pop means accumulator with flags
   assign pair_field = out_opcode_q[5:4];
   assign restart_vector = {10'h000, out_opcode_q[5:3], 3'h0};
   assign halted = halted_q;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave, one write and one read in flight
   assign awready = !aw_got_q && !bvalid_q;
   assign wready = !w_got_q && !bvalid_q;
   assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
   assign wr_ctrl = wr_fire && awaddr_q == REG_CTRL && wstrb_q[0];
   assign wr_status = wr_fire && awaddr_q == REG_STATUS && wstrb_q[0];
   assign halt_clear = wr_status && wdata_q[STAT_HALT_BIT];
   // A halt arriving with the clear still wins
   assign halt_set = finish && dec_class == halt_op;
   assign arready = !rvalid_q;
   assign rd_fire = arvalid && arready;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   always_comb begin
      dec_word = 32'h0;
      dec_word[DEC_OPCODE_LSB +: 8] = out_opcode_q;
      dec_word[DEC_LEN_LSB +: 2] = len_q;
      dec_word[DEC_TAKEN_BIT] = taken_out_q;
      dec_word[DEC_ILLEGAL_BIT] = illegal_q;
      dec_word[DEC_CYC_LSB +: 5] = cyc_q;
      dec_word[DEC_CLASS_LSB +: 5] = class_q;
   end

   assign rd_word = (araddr == REG_CTRL) ? {31'h0, enable_q} :
                    (araddr == REG_STATUS) ? {30'h0, state_q != st_opcode, halted_q} :
                    (araddr == REG_DECODE) ? dec_word :
                    (araddr == REG_OPERAND) ? {16'h0, out_high_q, out_low_q} :
                    (araddr == REG_COUNT) ? count_q : 32'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_got_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= addr_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= addr_known(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_q <= CTRL_ENABLE_RST;
         halted_q <= 1'b0;
      end else begin
         if (wr_ctrl) enable_q <= wdata_q[CTRL_ENABLE_BIT];
         if (halt_set) halted_q <= 1'b1;
         else if (halt_clear) halted_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_len_legal: assert property (
      @(posedge aclk) disable iff (!aresetn)
      insn_done |-> insn_len != 2'h0)
      else $error("decoded length out of range");

   chk_three_byte: assert property (
      @(posedge aclk) disable iff (!aresetn)
      fetch_fire && state_q == st_high |=>
         insn_done && insn_len == LEN_THREE && insn_operand[15:8] == $past(fetch_byte))
      else $error("third byte not taken as high half");

   chk_halt_stall: assert property (
      @(posedge aclk) disable iff (!aresetn)
      insn_done && insn_class == halt_op |-> halted && !fetch_ready)
      else $error("halt did not stop fetching");

   chk_copy_cycles: assert property (
      @(posedge aclk) disable iff (!aresetn)
      insn_done && insn_class == copy_op |->
         insn_cycles == ((reg_is_mem(dest_reg_field) || reg_is_mem(src_reg_field)) ?
                         CYC_MEM : CYC_REG))
      else $error("copy cycle count wrong");

   chk_alu_cycles: assert property (
      @(posedge aclk) disable iff (!aresetn)
      insn_done && insn_class == acc_reg_op |->
         insn_cycles == (reg_is_mem(src_reg_field) ? CYC_MEM : CYC_SHORT))
      else $error("accumulator register op cycle count wrong");

   chk_imm_shape: assert property (
      @(posedge aclk) disable iff (!aresetn)
      insn_done && insn_class == acc_imm_op |-> insn_len == LEN_TWO && insn_cycles == CYC_MEM)
      else $error("immediate accumulator op shape wrong");

   chk_ret_cycles: assert property (
      @(posedge aclk) disable iff (!aresetn)
      insn_done && insn_class == return_op && insn_opcode[2:0] == 3'h0 |->
         insn_cycles == (insn_taken ? CYC_PUSH : CYC_REG))
      else $error("conditional return cycle count wrong");

   chk_call_cycles: assert property (
      @(posedge aclk) disable iff (!aresetn)
      insn_done && insn_class == call_op |->
         insn_len == LEN_THREE && insn_cycles == (insn_taken || insn_opcode[0] ? CYC_CALL : CYC_PUSH))
      else $error("call cycle count wrong");

   chk_port_shape: assert property (
      @(posedge aclk) disable iff (!aresetn)
      insn_done && (insn_class == port_in_op || insn_class == port_out_op) |->
         insn_len == LEN_TWO && insn_cycles == CYC_WORD)
      else $error("port instruction shape wrong");

   chk_swap_stack: assert property (
      @(posedge aclk) disable iff (!aresetn)
      insn_done && insn_class == swap_stack_top_hl |-> insn_cycles == CYC_SWAP_STACK)
      else $error("stack swap cycle count wrong");
endmodule : cpu_instruction_decoder

// [verif/prog_mem.sv]
`timescale 1ns/1ps
module prog_mem (
   input wire logic aclk,
   input wire logic slow,
   input wire logic fetch_ready,
   output logic fetch_valid,
   output logic [7:0] fetch_byte
);
   logic [7:0] mem_q [0:255];
   logic [7:0] last_q = 8'h00;
   logic gap_q = 1'b0;
   int rd_q = 0;
   int top_q = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Opcode first, operands at rising addresses
   assign fetch_valid = !gap_q && rd_q < top_q;
   // Idle bus never repeats the last byte, so a late sample shows
   assign fetch_byte = fetch_valid ? mem_q[rd_q] : ~last_q;
   always @(posedge aclk) begin
      gap_q <= fetch_valid && fetch_ready && slow;
      if (fetch_valid && fetch_ready) begin
         rd_q <= rd_q + 1;
         last_q <= mem_q[rd_q];
      end
   end
endmodule : prog_mem

// [verif/cpu_instruction_decoder_tb_top.sv]
`timescale 1ns/1ps
module cpu_instruction_decoder_tb_top;
   import cpu_decode_pkg::*;
   typedef struct {logic [7:0] op; logic [1:0] len; logic [4:0] cyc; logic [15:0] opd;
                   logic tk;} exp_t;
   // Row: opcode, length, taken and cycles with flags clear, then with flags set
   localparam logic [27:0] prog [39] = '{
      28'h4110505, 28'h4610707, 28'h0e20707, 28'h3620a0a, 28'h9f10404, 28'h8610707,
      28'hfe20707, 28'h2710404, 28'hc012b05, 28'hc81052b, 28'hc910a0a, 28'hda30a2a,
      28'hcc30b31, 28'hc43310b, 28'hcd31111, 28'hdb20a0a, 28'h3130a0a, 28'hf510b0b,
      28'hf110a0a, 28'h3910a0a, 28'h3410a0a, 28'h2b10505, 28'he311212, 28'heb10404,
      28'he910505, 28'h3230d0d, 28'h2a31010, 28'h1a10707, 28'hfb10404, 28'hff10b0b,
      28'he012b05, 28'hf81052b, 28'h0210707, 28'h2231010, 28'h3a30d0d, 28'hd320a0a,
      28'hc330a0a, 28'h0810404, 28'h7610707};
   logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [2:0] awprot = 3'h0, arprot = 3'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf, flg = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, fetch_valid, fetch_ready, insn_done, halted;
   logic [1:0] bresp, rresp, insn_len, pair_field;
   logic insn_taken;
   op_class_t insn_class;
   logic [7:0] fetch_byte, insn_opcode;
   logic [15:0] insn_operand, restart_vector;
   logic [4:0] insn_cycles;
   logic [2:0] dest_reg_field, src_reg_field;
   int bad_count = 0, cmp_count = 0;
   exp_t exp_q [$];
   exp_t mon_e;
   initial forever #12.5 aclk = ~aclk;
   cpu_instruction_decoder i_cpu_instruction_decoder (.flag_zero(flg[3]), .flag_carry(flg[2]),
      .flag_parity(flg[1]), .flag_sign(flg[0]), .*);
   prog_mem i_prog_mem (.aclk(aclk), .slow(slow), .fetch_ready(fetch_ready),
      .fetch_valid(fetch_valid), .fetch_byte(fetch_byte));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         awvalid <= awvalid && !awready;
         wvalid <= wvalid && !wready;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge aclk); while (bvalid !== 1'b1);
      chk("bresp", er, bresp);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, m, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      chk("rdata", ed, rdata & m);
      chk("rresp", er, rresp);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic load(input logic fl);
      exp_t e;
      for (int i = 0; i < 39; i++) begin
         e.op = prog[i][27:20];
         e.len = prog[i][17:16];
         e.cyc = fl ? prog[i][4:0] : prog[i][12:8];
         e.tk = fl ? prog[i][5] : prog[i][13];
         e.opd = {e.len == 2'h3 ? e.op ^ 8'h5a : 8'h00, e.len > 2'h1 ? ~e.op : 8'h00};
         i_prog_mem.mem_q[i_prog_mem.top_q] = e.op;
         i_prog_mem.mem_q[i_prog_mem.top_q + 1] = ~e.op;
         i_prog_mem.mem_q[i_prog_mem.top_q + 2] = e.op ^ 8'h5a;
         i_prog_mem.top_q += e.len;
         exp_q.push_back(e);
      end
   endtask : load
   task automatic close_out;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      if (insn_done === 1'b1 && exp_q.size() > 0) begin
         mon_e = exp_q.pop_front();
         chk("opcode", mon_e.op, insn_opcode);
         chk("length", mon_e.len, insn_len);
         chk("operand", mon_e.opd, insn_operand);
         chk("fields", {mon_e.op[5:0]}, {dest_reg_field, src_reg_field});
         chk("vector", {mon_e.op[5:3], 3'h0}, restart_vector);
         chk("taken", mon_e.tk, insn_taken);
         chk("pair", mon_e.op[5:4], pair_field);
         chk("cycles", mon_e.cyc, insn_cycles);
      end
   end
   initial begin
      repeat (5000) @(posedge aclk);
      bad_count++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(REG_CTRL, 32'h0, '1, RESP_OKAY);
      rd(REG_COUNT, 32'h0, '1, RESP_OKAY);
      rd(8'h14, 32'h0, '1, RESP_SLVERR);
      wr(8'h20, 32'h1, RESP_SLVERR);
      load(1'b1);
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      while (halted !== 1'b1) @(posedge aclk);
      rd(REG_STATUS, 32'h1, 32'h3, RESP_OKAY);
      chk("class", halt_op, insn_class);
      wr(REG_DECODE, '1, RESP_OKAY);
      rd(REG_DECODE, 32'h02070176, 32'h1f1f23ff, RESP_OKAY);
      rd(REG_COUNT, 32'h27, '1, RESP_OKAY);
      flg <= 4'h0;
      slow <= 1'b1;
      load(1'b0);
      wr(REG_STATUS, 32'h1, RESP_OKAY);
      while (halted !== 1'b1) @(posedge aclk);
      repeat (2) @(posedge aclk);
      chk("left", 32'h0, exp_q.size());
      close_out();
   end
endmodule : cpu_instruction_decoder_tb_top
